// file: core/timer_pair.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "timer_pair_map.svh"

module timer_pair
	import timer_pair_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic count_pin_timer0,
	input wire logic count_pin_timer1,
	input wire logic gate_pin_timer0,
	input wire logic gate_pin_timer1,
	input wire logic vector_ack_timer0,
	input wire logic vector_ack_timer1,
	output logic overflow_flag_timer0,
	output logic overflow_flag_timer1,
	output logic serial_bitrate_tick
);

	// ----------------------------------------
	// Registers and internal state
	// ----------------------------------------
	logic [7:0] timer_mode_register; // Gate, select, mode per nibble
	logic [3:0] timer_control_register; // Run bits and flags
	logic [1:0] clock_control_register; // Fast time-base bits
	logic [7:0] timer0_low_byte;
	logic [7:0] timer0_high_byte;
	logic [7:0] timer1_low_byte;
	logic [7:0] timer1_high_byte;
	phase_t phase_reg; // Machine cycle phase
	logic [1:0] slow_cnt_reg; // Machine cycles within slow tick
	logic [1:0] pin_meta_reg; // Count pin first stage
	logic [1:0] pin_sync_reg; // Count pin second stage
	logic [1:0] gate_meta_reg; // Gate pin first stage
	logic [1:0] gate_sync_reg; // Gate pin second stage
	logic [1:0] pin_sample_reg; // Last phase-four sample
	logic [1:0] edge_pend_reg; // Edge waiting for next cycle
	logic bitrate_reg; // Serial tick register

	// Decoded controls
	mode_t mode0, mode1;
	logic run0, run1, ovf0, ovf1;
	logic wr_en, rd_en;
	logic at_three, at_four, slow_tick, tick0, tick1;
	logic inc0, inc1, inc0_high;
	logic [16:0] step0, step1; // {overflow, high, low}
	logic [8:0] split_low, split_high;
	logic set_ovf0, set_ovf1, t1_wrap;
	logic [7:0] t0l_next, t0h_next, t1l_next, t1h_next;

	assign mode0 = mode_t'(timer_mode_register[1:0]);
	assign mode1 = mode_t'(timer_mode_register[5:4]);
	assign run0 = timer_control_register[`CTRL_RUN0];
	assign run1 = timer_control_register[`CTRL_RUN1];
	assign ovf0 = timer_control_register[`CTRL_OVF0];
	assign ovf1 = timer_control_register[`CTRL_OVF1];
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// ----------------------------------------
	// One count step in modes 0 to 2
	// ----------------------------------------
	function automatic logic [16:0] count_step(
		input mode_t m,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [5:0] lo5;
		logic [8:0] hi9;
		logic [16:0] full;
		logic [8:0] lo9;
		lo5 = {1'b0, lo[4:0]} + 6'h01;
		hi9 = {1'b0, hi} + 9'h001;
		full = {1'b0, hi, lo} + 17'h00001;
		lo9 = {1'b0, lo} + 9'h001;
		count_step = {1'b0, hi, lo};
		case (m)
			MODE_13BIT: begin
				// Upper three low bits held as written
				if (lo5[5]) begin
					count_step = {hi9[8], hi9[7:0], lo[7:5], 5'h00};
				end else begin
					count_step = {1'b0, hi, lo[7:5], lo5[4:0]};
				end
			end
			MODE_16BIT: count_step = full;
			MODE_RELOAD: begin
				// Reload from high byte on wrap
				if (lo9[8]) begin
					count_step = {1'b1, hi, hi};
				end else begin
					count_step = {1'b0, hi, lo9[7:0]};
				end
			end
			default: count_step = {1'b0, hi, lo}; // Frozen
		endcase
	endfunction

	// ----------------------------------------
	// Machine cycle phase and time base
	// ----------------------------------------
	// Four-clock machine cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= PHASE_ONE;
		end else begin
			phase_reg <= phase_t'(phase_reg + 2'h1);
		end
	end

	// Divide machine cycles by three for the slow rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cnt_reg <= 2'h0;
		end else if (at_four) begin
			slow_cnt_reg <= (slow_cnt_reg == `SLOW_LAST) ? 2'h0 :
				slow_cnt_reg + 2'h1;
		end
	end

	assign at_three = (phase_reg == PHASE_THREE);
	assign at_four = (phase_reg == PHASE_FOUR);
	assign slow_tick = at_three & (slow_cnt_reg == `SLOW_LAST);
	// Fast: every machine cycle; slow: every third
	assign tick0 = clock_control_register[`CLK_FAST0] ? at_three :
		slow_tick;
	assign tick1 = clock_control_register[`CLK_FAST1] ? at_three :
		slow_tick;

	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	// Two-stage synchronisers for count and gate pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			gate_meta_reg <= 2'h0;
			gate_sync_reg <= 2'h0;
		end else begin
			pin_meta_reg <= {count_pin_timer1, count_pin_timer0};
			pin_sync_reg <= pin_meta_reg;
			gate_meta_reg <= {gate_pin_timer1, gate_pin_timer0};
			gate_sync_reg <= gate_meta_reg;
		end
	end

	// Sample at phase four, flag high-then-low for next cycle
	generate
		for (genvar i = 0; i < 2; i++) begin : g_edge
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_sample_reg[i] <= 1'b0;
					edge_pend_reg[i] <= 1'b0;
				end else if (at_four) begin
					pin_sample_reg[i] <= pin_sync_reg[i];
					edge_pend_reg[i] <= pin_sample_reg[i] &
						~pin_sync_reg[i];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Count enables and next values
	// ----------------------------------------
	always_comb begin
		// Timer 0: run and gate qualify the chosen source
		inc0 = at_three & run0 &
			(~timer_mode_register[`MODE_T0_GATE] | gate_sync_reg[0]) &
			(timer_mode_register[`MODE_T0_CT] ? edge_pend_reg[0] :
			tick0);
		// Split high byte: timer 1 run bit, ticks only
		inc0_high = tick0 & run1 & (mode0 == MODE_SPLIT);
		// Timer 1 loses its run bit while timer 0 is split
		inc1 = at_three & (run1 | (mode0 == MODE_SPLIT)) &
			(~timer_mode_register[`MODE_T1_GATE] | gate_sync_reg[1]) &
			(timer_mode_register[`MODE_T1_CT] ? edge_pend_reg[1] :
			tick1);
		step0 = count_step(mode0, timer0_high_byte, timer0_low_byte);
		step1 = count_step(mode1, timer1_high_byte, timer1_low_byte);
		split_low = {1'b0, timer0_low_byte} + 9'h001;
		split_high = {1'b0, timer0_high_byte} + 9'h001;
		t0l_next = timer0_low_byte;
		t0h_next = timer0_high_byte;
		t1l_next = timer1_low_byte;
		t1h_next = timer1_high_byte;
		set_ovf0 = 1'b0;
		set_ovf1 = 1'b0;
		t1_wrap = 1'b0;
		if (mode0 == MODE_SPLIT) begin
			if (inc0) begin
				t0l_next = split_low[7:0];
				set_ovf0 = split_low[8];
			end
			if (inc0_high) begin
				t0h_next = split_high[7:0];
				set_ovf1 = split_high[8];
			end
		end else if (inc0) begin
			{set_ovf0, t0h_next, t0l_next} = step0;
		end
		// Mode 3 of timer 1 returns its count unchanged
		if (inc1 && mode1 != MODE_SPLIT) begin
			{t1_wrap, t1h_next, t1l_next} = step1;
			if (mode0 != MODE_SPLIT) begin
				set_ovf1 = step1[16];
			end
		end
	end

	// ----------------------------------------
	// Count bytes
	// ----------------------------------------
	// Software writes replace the byte at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer0_low_byte <= `RST_BYTE;
			timer0_high_byte <= `RST_BYTE;
			timer1_low_byte <= `RST_BYTE;
			timer1_high_byte <= `RST_BYTE;
		end else begin
			timer0_low_byte <= (wr_en && paddr == `OFF_T0_LOW) ?
				pwdata[7:0] : t0l_next;
			timer0_high_byte <= (wr_en && paddr == `OFF_T0_HIGH) ?
				pwdata[7:0] : t0h_next;
			timer1_low_byte <= (wr_en && paddr == `OFF_T1_LOW) ?
				pwdata[7:0] : t1l_next;
			timer1_high_byte <= (wr_en && paddr == `OFF_T1_HIGH) ?
				pwdata[7:0] : t1h_next;
		end
	end

	// ----------------------------------------
	// Mode, clock and control registers
	// ----------------------------------------
	// Configuration written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_register <= `RST_BYTE;
			clock_control_register <= 2'h0;
		end else if (wr_en) begin
			if (paddr == `OFF_MODE) begin
				timer_mode_register <= pwdata[7:0];
			end
			if (paddr == `OFF_CLKCTL) begin
				clock_control_register <= pwdata[1:0];
			end
		end
	end

	// Run bits and flags; hardware set wins over any clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_register <= 4'h0;
		end else begin
			if (wr_en && paddr == `OFF_CTRL) begin
				timer_control_register <= pwdata[3:0];
			end
			if (vector_ack_timer0) begin
				timer_control_register[`CTRL_OVF0] <= 1'b0;
			end
			if (vector_ack_timer1) begin
				timer_control_register[`CTRL_OVF1] <= 1'b0;
			end
			if (set_ovf0) begin
				timer_control_register[`CTRL_OVF0] <= 1'b1;
			end
			if (set_ovf1) begin
				timer_control_register[`CTRL_OVF1] <= 1'b1;
			end
		end
	end

	// Serial bit-rate tick from any timer 1 wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitrate_reg <= 1'b0;
		end else begin
			bitrate_reg <= t1_wrap;
		end
	end

	assign overflow_flag_timer0 = ovf0;
	assign overflow_flag_timer1 = ovf1;
	assign serial_bitrate_tick = bitrate_reg;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(paddr == `OFF_MODE ||
		paddr == `OFF_CTRL || paddr == `OFF_CLKCTL ||
		paddr == `OFF_T0_LOW || paddr == `OFF_T0_HIGH ||
		paddr == `OFF_T1_LOW || paddr == `OFF_T1_HIGH);

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr)
				`OFF_MODE: prdata <= {24'h0, timer_mode_register};
				`OFF_CTRL: prdata <= {28'h0, timer_control_register};
				`OFF_CLKCTL: prdata <= {30'h0, clock_control_register};
				`OFF_T0_LOW: prdata <= {24'h0, timer0_low_byte};
				`OFF_T0_HIGH: prdata <= {24'h0, timer0_high_byte};
				`OFF_T1_LOW: prdata <= {24'h0, timer1_low_byte};
				`OFF_T1_HIGH: prdata <= {24'h0, timer1_high_byte};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	count_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
		(inc0 | inc1) |-> phase_reg == PHASE_THREE)
		else $error("count outside phase three");
	edge_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(edge_pend_reg[0]) |-> $past(phase_reg) == PHASE_FOUR)
		else $error("edge not taken at phase four");
	slow_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(slow_tick && !clock_control_register[`CLK_FAST0]) |=>
		(!tick0 || clock_control_register[`CLK_FAST0]) [*8])
		else $error("slow tick too frequent");
	gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!run0 || (timer_mode_register[`MODE_T0_GATE] &&
		!gate_sync_reg[0])) |-> !inc0)
		else $error("timer 0 counted while disabled");
	freeze_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode1 == MODE_SPLIT && !wr_en) |=>
		$stable(timer1_low_byte) && $stable(timer1_high_byte))
		else $error("timer 1 moved in mode 3");
	wrap13_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode0 == MODE_13BIT && inc0 && !wr_en &&
		timer0_high_byte == 8'hFF && timer0_low_byte[4:0] == 5'h1F) |=>
		ovf0 && timer0_high_byte == 8'h00 &&
		timer0_low_byte[4:0] == 5'h00)
		else $error("13-bit wrap wrong");
	reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode0 == MODE_RELOAD && inc0 && !wr_en &&
		timer0_low_byte == 8'hFF) |=>
		timer0_low_byte == $past(timer0_high_byte) && ovf0)
		else $error("reload wrong");
	ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(vector_ack_timer0 && !set_ovf0 && !wr_en) |=> !ovf0)
		else $error("flag kept after vectoring");
	bitrate_a: assert property (@(posedge pclk) disable iff (!presetn)
		serial_bitrate_tick |-> $past(inc1) &&
		$past(mode1) != MODE_SPLIT)
		else $error("bit-rate tick without wrap");

endmodule

// file: core/timer_pair_map.svh
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH

// Register byte offsets
`define OFF_MODE 8'h00
`define OFF_CTRL 8'h04
`define OFF_CLKCTL 8'h08
`define OFF_T0_LOW 8'h0C
`define OFF_T0_HIGH 8'h10
`define OFF_T1_LOW 8'h14
`define OFF_T1_HIGH 8'h18

// Mode register fields
`define MODE_T0_SEL_LO 0
`define MODE_T0_SEL_HI 1
`define MODE_T0_CT 2
`define MODE_T0_GATE 3
`define MODE_T1_SEL_LO 4
`define MODE_T1_SEL_HI 5
`define MODE_T1_CT 6
`define MODE_T1_GATE 7

// Control register fields
`define CTRL_RUN0 0
`define CTRL_RUN1 1
`define CTRL_OVF0 2
`define CTRL_OVF1 3

// Clock control fields
`define CLK_FAST0 0
`define CLK_FAST1 1

// Reset values
`define RST_BYTE 8'h00

// Machine cycles per slow tick (twelve clocks over four-clock cycles)
`define SLOW_DIV 2'h3
`define SLOW_LAST 2'h2

`endif

// file: core/timer_pair_pkg.sv
package timer_pair_pkg;
	// Four clock phases of one machine cycle
	typedef enum logic [1:0] {
		PHASE_ONE,
		PHASE_TWO,
		PHASE_THREE,
		PHASE_FOUR
	} phase_t;
	// Operating modes in select-bit order
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPLIT
	} mode_t;
endpackage

// file: verif/timer_pair_partner.sv
`timescale 1ns/1ps
// ------------------------------------------
// Far-side pins: count and gate pins, acks
// ------------------------------------------
module timer_pair_partner (
	input wire logic pclk,
	output logic count_pin_timer0,
	output logic count_pin_timer1,
	output logic gate_pin_timer0,
	output logic gate_pin_timer1,
	output logic vector_ack_timer0,
	output logic vector_ack_timer1
);
	// Idle: pins high, acknowledges low
	initial begin
		count_pin_timer0 = 1'b1;
		count_pin_timer1 = 1'b1;
		gate_pin_timer0 = 1'b1;
		gate_pin_timer1 = 1'b1;
		vector_ack_timer0 = 1'b0;
		vector_ack_timer1 = 1'b0;
	end
	// Falling edges, low held 12 clocks and high 13, a 25-clock period
	task pulse(input int n, input int p = 0);
		repeat (n) begin
			@(posedge pclk);
			if (p == 1) begin
				count_pin_timer1 <= 1'b0;
			end else begin
				count_pin_timer0 <= 1'b0;
			end
			repeat (12) @(posedge pclk);
			if (p == 1) begin
				count_pin_timer1 <= 1'b1;
			end else begin
				count_pin_timer0 <= 1'b1;
			end
			repeat (12) @(posedge pclk);
		end
	endtask
	// Gate pin level for timer 0
	task gate(input logic v);
		@(posedge pclk) gate_pin_timer0 <= v;
	endtask
	// One-cycle vector acknowledge for the chosen timer
	task ack(input int p = 0);
		@(posedge pclk);
		if (p == 1) begin
			vector_ack_timer1 <= 1'b1;
		end else begin
			vector_ack_timer0 <= 1'b1;
		end
		@(posedge pclk);
		vector_ack_timer0 <= 1'b0;
		vector_ack_timer1 <= 1'b0;
	endtask
endmodule

// file: verif/dual_timer_counter_four_modes_test.sv
`timescale 1ns/1ps
`include "timer_pair_map.svh"
module dual_timer_counter_four_modes_test;
	// ------------------------------------------
	// Signals
	// ------------------------------------------
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, hit;
	logic cp0, cp1, gp0, gp1, ack0, ack1, flag0, flag1, tick;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int ex;
	wire [2:0] sigs = {tick, flag1, flag0}; // Watched outputs

	always #10 pclk = ~pclk; // 50 MHz clock

	timer_pair i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_pin_timer0(cp0),
		.count_pin_timer1(cp1), .gate_pin_timer0(gp0),
		.gate_pin_timer1(gp1), .vector_ack_timer0(ack0),
		.vector_ack_timer1(ack1), .overflow_flag_timer0(flag0),
		.overflow_flag_timer1(flag1), .serial_bitrate_tick(tick));
	timer_pair_partner i_partner (.pclk(pclk), .count_pin_timer0(cp0),
		.count_pin_timer1(cp1), .gate_pin_timer0(gp0),
		.gate_pin_timer1(gp1), .vector_ack_timer0(ack0),
		.vector_ack_timer1(ack1));

	// ------------------------------------------
	// Tasks
	// ------------------------------------------
	// Verdict and end of run
	task final_report;
		$display("Counts: compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Value compare
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp=%h got=%h", nm, e, g);
		end
	endtask
	// APB write: setup, access until pready
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= 1'b1;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// APB read, data and error taken at the completing edge
	task rdr(input logic [7:0] a, output logic [31:0] d, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Bounded wait for one watched output
	task waitfor(input int s, output logic h);
		h = 1'b0;
		for (int i = 0; i < 100 && !h; i++) begin
			@(negedge pclk);
			h = (sigs[s] === 1'b1);
		end
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			final_report;
		end
	end

	// ------------------------------------------
	// Tests
	// ------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdr(`OFF_CLKCTL, rd, err);
		chk("clkctl reset", 32'h0, rd); // Slow rate after reset
		rdr(`OFF_MODE, rd, err);
		chk("mode reset", 32'h0, rd); // Mode bits clear
		rdr(8'h40, rd, err);
		chk("unmapped err", 32'h1, {31'h0, err});
		$display("Test reset done");
		for (int f = 1; f >= 0; f--) begin
			ex = f ? 240 / 4 : 240 / 12;
			wr(`OFF_CLKCTL, 32'(f)); // Time-base select
			wr(`OFF_MODE, 32'h01); // Timer 0 mode 1
			wr(`OFF_T0_LOW, 32'h0);
			wr(`OFF_T0_HIGH, 32'h0);
			wr(`OFF_CTRL, 32'h1);
			repeat (240) @(posedge pclk);
			wr(`OFF_CTRL, 32'h0);
			rdr(`OFF_T0_LOW, rd, err);
			chk("tick rate", 32'h1, {31'h0, rd >= ex - 1 && rd <= ex + 2});
		end
		$display("Test rate done");
		wr(`OFF_CLKCTL, 32'h3);
		wr(`OFF_T0_LOW, 32'hFE);
		wr(`OFF_T0_HIGH, 32'hFF); // Write then count on
		wr(`OFF_CTRL, 32'h1);
		waitfor(0, hit);
		chk("t0 wrap", 32'h1, {31'h0, hit}); // Full rollover flag
		rdr(`OFF_CTRL, rd, err);
		chk("ctrl flag0", 32'h1, {31'h0, rd[`CTRL_OVF0]}); // Flag bit
		i_partner.ack();
		@(negedge pclk);
		chk("ack clear", 32'h0, {31'h0, flag0}); // Vectoring clears
		wr(`OFF_CTRL, 32'h0);
		$display("Test mode1 done");
		wr(`OFF_T1_LOW, 32'hFF);
		wr(`OFF_T1_HIGH, 32'hFF);
		wr(`OFF_MODE, 32'h0);
		wr(`OFF_CTRL, 32'h2);
		waitfor(2, hit);
		chk("t1 tick", 32'h1, {31'h0, hit}); // Serial rate tick
		chk("t1 flag", 32'h1, {31'h0, flag1}); // 13-bit rollover
		wr(`OFF_CTRL, 32'h0);
		rdr(`OFF_T1_HIGH, rd, err);
		chk("t1 high", 32'h0, rd); // High byte wrapped
		rdr(`OFF_T1_LOW, rd, err);
		chk("t1 low top", 32'h7, {29'h0, rd[7:5]}); // Top bits ignored
		$display("Test mode0 done");
		wr(`OFF_T0_HIGH, 32'hA5);
		wr(`OFF_T0_LOW, 32'hFE);
		wr(`OFF_MODE, 32'h02);
		wr(`OFF_CTRL, 32'h1);
		waitfor(0, hit);
		chk("reload flag", 32'h1, {31'h0, hit}); // Low byte wrap
		wr(`OFF_CTRL, 32'h0);
		rdr(`OFF_T0_HIGH, rd, err);
		chk("reload high", 32'hA5, rd); // High byte kept
		rdr(`OFF_T0_LOW, rd, err);
		chk("reload low", 32'h1, {31'h0, rd >= 32'hA5 && rd <= 32'hAD});
		$display("Test mode2 done");
		wr(`OFF_MODE, 32'h05); // Counter select bit 2
		wr(`OFF_T0_LOW, 32'h0);
		wr(`OFF_T0_HIGH, 32'h0);
		wr(`OFF_CTRL, 32'h1);
		i_partner.pulse(3);
		repeat (16) @(posedge pclk);
		rdr(`OFF_T0_LOW, rd, err);
		chk("edge count", 32'h3, rd); // Falling edges counted
		i_partner.gate(1'b0);
		wr(`OFF_MODE, 32'h0D);
		i_partner.pulse(2);
		repeat (16) @(posedge pclk);
		rdr(`OFF_T0_LOW, rd, err);
		chk("gated off", 32'h3, rd); // Gate pin low blocks
		i_partner.gate(1'b1);
		i_partner.pulse(2);
		repeat (16) @(posedge pclk);
		rdr(`OFF_T0_LOW, rd, err);
		chk("gated on", 32'h5, rd); // Gate pin high counts
		$display("Test counter done");
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_T1_LOW, 32'h10);
		wr(`OFF_MODE, 32'h31);
		wr(`OFF_CTRL, 32'h2);
		repeat (100) @(posedge pclk);
		rdr(`OFF_T1_LOW, rd, err);
		chk("t1 frozen", 32'h10, rd); // Timer 1 mode 3 holds
		wr(`OFF_T0_HIGH, 32'hFF);
		wr(`OFF_T0_LOW, 32'h40);
		wr(`OFF_MODE, 32'h33);
		waitfor(1, hit);
		chk("split high", 32'h1, {31'h0, hit}); // Run1 and flag1 used
		rdr(`OFF_T0_LOW, rd, err);
		chk("split low", 32'h40, rd); // Run0 off holds low
		i_partner.ack(1);
		@(negedge pclk);
		chk("ack1 clear", 32'h0, {31'h0, flag1}); // Vectoring clears
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_T1_LOW, 32'hFE);
		wr(`OFF_MODE, 32'h23);
		waitfor(2, hit);
		chk("t1 in split", 32'h1, {31'h0, hit}); // Runs without run1
		chk("t1 no flag", 32'h0, {31'h0, flag1}); // No flag control
		$display("Test split done");
		wr(`OFF_MODE, 32'h50); // Timer 1 counts its pin
		wr(`OFF_T0_LOW, 32'h1F);
		wr(`OFF_T0_HIGH, 32'hFF);
		wr(`OFF_T1_LOW, 32'h0);
		wr(`OFF_CTRL, 32'h3);
		i_partner.pulse(2, 1); // Pin edges, 25-clock period
		repeat (16) @(posedge pclk);
		rdr(`OFF_T1_LOW, rd, err);
		chk("t1 edges", 32'h2, rd); // Bit 6 selects counting
		chk("t0 wrap13", 32'h1, {31'h0, flag0}); // 1FFF rolls over
		rdr(`OFF_T0_HIGH, rd, err);
		chk("t0 high wrap", 32'h0, rd); // High byte FF to 00
		$display("Test pins done");
		final_report;
	end
endmodule
